// ===== design/sfid_regs.vh
// Constants shared by the serial flash host controller files.
`ifndef SFID_REGS_VH
`define SFID_REGS_VH
// ****************************************************************
// Instruction codes.
// ****************************************************************
`define SFID_OP_WREN      8'h06
`define SFID_OP_WRDI      8'h04
`define SFID_OP_WREN_VOL  8'h50
`define SFID_OP_RD_STAT   8'h05
`define SFID_OP_WR_STAT   8'h01
`define SFID_OP_READ      8'h03
`define SFID_OP_FAST      8'h0B
`define SFID_OP_FAST_DO   8'h3B
`define SFID_OP_FAST_DIO  8'hBB
`define SFID_OP_PROG      8'h02
`define SFID_OP_ERASE_4K  8'h20
`define SFID_OP_ERASE_32K 8'h52
`define SFID_OP_ERASE_64K 8'hD8
`define SFID_OP_CHIP_A    8'hC7
`define SFID_OP_CHIP_B    8'h60
`define SFID_OP_PWR_DOWN  8'hB9
`define SFID_OP_REL_PD    8'hAB
`define SFID_OP_MAKER_ID  8'h90
`define SFID_OP_MAKER_DIO 8'h92
`define SFID_OP_JEDEC_ID  8'h9F
`define SFID_OP_UNIQUE_ID 8'h4B
// ****************************************************************
// Transfer shape figures.
// ****************************************************************
`define SFID_PAGE_BYTES   16'h0100
`define SFID_BITS_SINGLE  4'h8
`define SFID_BITS_DUAL    4'h4
`define SFID_ADDR_SINGLE  3'h3
`define SFID_ADDR_DUAL    3'h4
`define SFID_DUMMY_FAST   3'h1
`define SFID_DUMMY_ID     3'h3
`define SFID_DUMMY_UID    3'h4
// ****************************************************************
// Sequencer states and instruction phases.
// ****************************************************************
`define SFID_S_IDLE  3'h0
`define SFID_S_SETUP 3'h1
`define SFID_S_RUN   3'h2
`define SFID_S_WAITW 3'h3
`define SFID_S_HOLD  3'h4
`define SFID_S_GAP   3'h5
`define SFID_P_OPC   3'h0
`define SFID_P_ADDR  3'h1
`define SFID_P_DUMMY 3'h2
`define SFID_P_WDATA 3'h3
`define SFID_P_RDATA 3'h4
`define SFID_P_END   3'h5
// ****************************************************************
// Timing, in ns.
// ****************************************************************
`define SFID_CLK_NS      4
`define SFID_SCK_HALF_NS 64
`define SFID_CSS_NS      20
`define SFID_CSH_NS      20
`define SFID_CS_GAP_NS   100
`endif

// ===== design/sfid_sck_gen.v
// Serial clock divider that makes the link clock and marks its edges.
`timescale 1ns/100ps
module sfid_sck_gen #(
  parameter HALF = 16
) (
  input  wire clk,      // System clock.
  input  wire sys_rst,  // Synchronous reset, active high.
  input  wire run,      // Level: let the serial clock toggle.
  output wire sck,      // Serial clock, idles low.
  output wire rise_evt, // Pulse: sck goes high at this edge.
  output wire fall_evt  // Pulse: sck goes low at this edge.
);
  localparam [7:0] HALF_M1 = HALF - 1;

  reg  [7:0] cnt_reg;
  reg        sck_reg;
  wire       tick;

  // ****************************************************************
  // Edge marks.
  // ****************************************************************
  // The marks are combinational so the sequencer acts on the very edge that moves sck.
  assign tick     = run && (cnt_reg == 8'h00);
  assign rise_evt = tick && !sck_reg;
  assign fall_evt = tick && sck_reg;
  assign sck      = sck_reg;

  // ****************************************************************
  // Divider.
  // ****************************************************************
  // Restarting on every stop gives a full half period before the first rise.
  always @(posedge clk)
  begin
    if (sys_rst || !run)
    begin
      cnt_reg <= HALF_M1;
      sck_reg <= 1'b0;
    end
    else if (tick)
    begin
      cnt_reg <= HALF_M1;
      sck_reg <= !sck_reg;
    end
    else
    begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule

// ===== design/sfid_host.v
// Host controller that sequences serial flash instructions over a single or dual lane link.
`timescale 1ns/100ps
`include "sfid_regs.vh"
module sfid_host #(
  parameter LEN_W    = 16,
  parameter SCK_HALF = (`SFID_SCK_HALF_NS + `SFID_CLK_NS - 1) / `SFID_CLK_NS
) (
  input  wire             clk,        // System clock, 250 MHz.
  input  wire             sys_rst,    // Synchronous reset, active high.
  input  wire             cmd_valid,  // Instruction request.
  output reg              cmd_ready,  // Controller idle, request taken when both high.
  input  wire [7:0]       cmd_opcode, // Instruction code.
  input  wire [23:0]      cmd_addr,   // Flash address.
  input  wire [7:0]       cmd_mode,   // Continuation mode byte for two-lane address.
  input  wire [LEN_W-1:0] cmd_count,  // Data bytes to read or write.
  input  wire [7:0]       wr_data,    // Next byte to program or write.
  input  wire             wr_valid,   // Write byte present.
  output reg              wr_ack,     // Pulse: write byte was taken one edge earlier.
  output reg  [7:0]       rd_data,    // Byte returned by the flash.
  output reg              rd_valid,   // Pulse: rd_data is new.
  output reg              busy,       // Instruction in progress.
  output wire             flash_sck,  // Serial clock to the flash.
  output reg              flash_cs_n, // Chip select, active low.
  output reg              lane0_out,  // Serial input or second lane, driven value.
  output reg              lane0_oe,   // Drive enable for lane 0.
  input  wire             lane0_in,   // Lane 0 pin level.
  output reg              lane1_out,  // Serial output lane, driven value.
  output reg              lane1_oe,   // Drive enable for lane 1.
  input  wire             lane1_in    // Lane 1 pin level.
);
  localparam [7:0] SETUP_CYC = (`SFID_CSS_NS + `SFID_CLK_NS - 1) / `SFID_CLK_NS;
  localparam [7:0] HOLD_CYC  = (`SFID_CSH_NS + `SFID_CLK_NS - 1) / `SFID_CLK_NS;
  localparam [7:0] GAP_CYC   = (`SFID_CS_GAP_NS + `SFID_CLK_NS - 1) / `SFID_CLK_NS;
  localparam [LEN_W-1:0] PAGE_MAX = `SFID_PAGE_BYTES;
  localparam [LEN_W-1:0] ONE      = 1;

  reg  [2:0]       state_reg, state_next;
  reg  [2:0]       phase_reg, phase_next;
  reg  [31:0]      tx_reg, tx_next;
  reg              dual_reg, dual_next;
  reg  [3:0]       bcnt_reg, bcnt_next;
  reg  [LEN_W-1:0] nbyte_reg, nbyte_next;
  reg  [7:0]       wait_reg, wait_next;
  reg  [7:0]       rx_reg, rx_next, rx_shift;
  reg  [31:0]      addr_reg, addr_next;
  reg              has_addr_reg, has_addr_next, addr_dual_reg, addr_dual_next;
  reg  [2:0]       dummy_reg, dummy_next;
  reg              dir_wr_reg, dir_wr_next, dir_rd_reg, dir_rd_next, rd_dual_reg, rd_dual_next;
  reg  [LEN_W-1:0] cnt_reg, cnt_next;
  reg              need_wr, active;
  reg  [2:0]       np;
  reg              cmd_ready_next, wr_ack_next, rd_valid_next, cs_n_next;
  reg  [7:0]       rd_data_next;
  reg  [1:0]       in_meta_reg, in_sync_reg;
  reg              d_addr, d_adual, d_wr, d_rd, d_rdual;
  reg  [2:0]       d_dummy;
  reg  [LEN_W-1:0] d_cnt;
  wire             run, rise_evt, fall_evt;

  // ****************************************************************
  // Serial clock.
  // ****************************************************************
  assign run = (state_reg == `SFID_S_RUN);

  sfid_sck_gen #(
    .HALF (SCK_HALF)
  ) u_sck (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .run      (run),
    .sck      (flash_sck),
    .rise_evt (rise_evt),
    .fall_evt (fall_evt)
  );

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  // Two flops per lane; only the second stage is read by the sequencer.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      in_meta_reg <= 2'h0;
      in_sync_reg <= 2'h0;
    end
    else
    begin
      in_meta_reg <= {lane1_in, lane0_in};
      in_sync_reg <= in_meta_reg;
    end
  end

  // ****************************************************************
  // Instruction shape decode.
  // ****************************************************************
  // Codes outside the set are sent alone so the flash simply drops them.
  always @*
  begin
    d_addr  = 1'b0;
    d_adual = 1'b0;
    d_dummy = 3'h0;
    d_wr    = 1'b0;
    d_rd    = 1'b0;
    d_rdual = 1'b0;
    d_cnt   = cmd_count;
    case (cmd_opcode)
      `SFID_OP_WREN, `SFID_OP_WRDI, `SFID_OP_WREN_VOL: d_cnt = {LEN_W{1'b0}};
      `SFID_OP_CHIP_A, `SFID_OP_CHIP_B:                d_cnt = {LEN_W{1'b0}};
      `SFID_OP_PWR_DOWN:                               d_cnt = {LEN_W{1'b0}};
      `SFID_OP_RD_STAT:  d_rd = 1'b1;
      `SFID_OP_WR_STAT:
      begin
        d_wr  = 1'b1;
        d_cnt = ONE;
      end
      `SFID_OP_READ:     {d_addr, d_rd} = 2'h3;
      `SFID_OP_FAST:
      begin
        {d_addr, d_rd} = 2'h3;
        d_dummy = `SFID_DUMMY_FAST;
      end
      `SFID_OP_FAST_DO:
      begin
        {d_addr, d_rd, d_rdual} = 3'h7;
        d_dummy = `SFID_DUMMY_FAST;
      end
      `SFID_OP_FAST_DIO, `SFID_OP_MAKER_DIO: {d_addr, d_adual, d_rd, d_rdual} = 4'hF;
      `SFID_OP_PROG:
      begin
        {d_addr, d_wr} = 2'h3;
        d_cnt = (cmd_count > PAGE_MAX) ? PAGE_MAX : cmd_count;
      end
      `SFID_OP_ERASE_4K, `SFID_OP_ERASE_32K, `SFID_OP_ERASE_64K:
      begin
        d_addr = 1'b1;
        d_cnt  = {LEN_W{1'b0}};
      end
      `SFID_OP_REL_PD, `SFID_OP_MAKER_ID:
      begin
        d_rd    = 1'b1;
        d_dummy = `SFID_DUMMY_ID;           // Zero filler also gives the trailing 00h.
      end
      `SFID_OP_JEDEC_ID: d_rd = 1'b1;
      `SFID_OP_UNIQUE_ID:
      begin
        d_rd    = 1'b1;
        d_dummy = `SFID_DUMMY_UID;
      end
      default:           d_cnt = {LEN_W{1'b0}};
    endcase
  end

  // ****************************************************************
  // Sequencer next state.
  // ****************************************************************
  always @*
  begin
    state_next     = state_reg;
    phase_next     = phase_reg;
    tx_next        = tx_reg;
    dual_next      = dual_reg;
    bcnt_next      = bcnt_reg;
    nbyte_next     = nbyte_reg;
    wait_next      = wait_reg;
    rx_next        = rx_reg;
    addr_next      = addr_reg;
    has_addr_next  = has_addr_reg;
    addr_dual_next = addr_dual_reg;
    dummy_next     = dummy_reg;
    dir_wr_next    = dir_wr_reg;
    dir_rd_next    = dir_rd_reg;
    rd_dual_next   = rd_dual_reg;
    cnt_next       = cnt_reg;
    cmd_ready_next = 1'b0;
    wr_ack_next    = 1'b0;
    rd_valid_next  = 1'b0;
    rd_data_next   = rd_data;
    cs_n_next      = flash_cs_n;
    need_wr        = 1'b0;
    // Dual receive takes the odd lane as the higher bit of each pair.
    rx_shift = dual_reg ? {rx_reg[5:0], in_sync_reg[1], in_sync_reg[0]} : {rx_reg[6:0], in_sync_reg[1]};
    // Phase that follows the current one.
    if (cnt_reg != {LEN_W{1'b0}} && (dir_wr_reg || dir_rd_reg))
      np = dir_wr_reg ? `SFID_P_WDATA : `SFID_P_RDATA;
    else
      np = `SFID_P_END;
    if (phase_reg == `SFID_P_OPC && dummy_reg != 3'h0 && !has_addr_reg)
      np = `SFID_P_DUMMY;
    if (phase_reg == `SFID_P_ADDR && dummy_reg != 3'h0)
      np = `SFID_P_DUMMY;
    if (phase_reg == `SFID_P_OPC && has_addr_reg)
      np = `SFID_P_ADDR;
    if (phase_reg == `SFID_P_WDATA || phase_reg == `SFID_P_RDATA)
      np = `SFID_P_END;
    case (state_reg)
      `SFID_S_IDLE:
      begin
        cmd_ready_next = 1'b1;
        if (cmd_valid && cmd_ready)
        begin
          cmd_ready_next = 1'b0;
          has_addr_next  = d_addr;
          addr_dual_next = d_adual;
          dummy_next     = d_dummy;
          dir_wr_next    = d_wr;
          dir_rd_next    = d_rd;
          rd_dual_next   = d_rdual;
          cnt_next       = d_cnt;
          addr_next      = {cmd_addr, cmd_mode};
          cs_n_next      = 1'b0;                 // Falling chip select opens the instruction.
          phase_next     = `SFID_P_OPC;
          tx_next        = {cmd_opcode, 24'h000000};
          dual_next      = 1'b0;
          bcnt_next      = `SFID_BITS_SINGLE;
          nbyte_next     = ONE;
          wait_next      = SETUP_CYC;
          state_next     = `SFID_S_SETUP;
        end
      end
      `SFID_S_SETUP:
      begin
        wait_next = wait_reg - 8'h01;
        if (wait_reg == 8'h00)
          state_next = `SFID_S_RUN;
      end
      `SFID_S_RUN:
      begin
        if (rise_evt)
        begin
          bcnt_next = bcnt_reg - 4'h1;
          if (phase_reg == `SFID_P_RDATA)
          begin
            rx_next = rx_shift;
            if (bcnt_reg == 4'h1)
            begin
              rd_data_next  = rx_shift;
              rd_valid_next = 1'b1;
            end
          end
        end
        else if (fall_evt)
        begin
          if (bcnt_reg != 4'h0)
            tx_next = dual_reg ? {tx_reg[29:0], 2'h0} : {tx_reg[30:0], 1'b0};
          else if (nbyte_reg != ONE)
          begin
            nbyte_next = nbyte_reg - ONE;
            bcnt_next  = dual_reg ? `SFID_BITS_DUAL : `SFID_BITS_SINGLE;
            need_wr    = (phase_reg == `SFID_P_WDATA);
            tx_next    = dual_reg ? {tx_reg[29:0], 2'h0} : {tx_reg[30:0], 1'b0};
          end
          else if (np == `SFID_P_END)
          begin
            // Only reached after the last clock of a whole byte.
            state_next = `SFID_S_HOLD;
            wait_next  = HOLD_CYC;
          end
          else
          begin
            phase_next = np;
            dual_next  = (np == `SFID_P_ADDR) ? addr_dual_reg : ((np == `SFID_P_RDATA) && rd_dual_reg);
            bcnt_next  = dual_next ? `SFID_BITS_DUAL : `SFID_BITS_SINGLE;
            tx_next    = (np == `SFID_P_ADDR) ? addr_reg : 32'h00000000;
            need_wr    = (np == `SFID_P_WDATA);
            if (np == `SFID_P_ADDR)
              nbyte_next = addr_dual_reg ? {{(LEN_W-3){1'b0}}, `SFID_ADDR_DUAL} :
                                           {{(LEN_W-3){1'b0}}, `SFID_ADDR_SINGLE};
            else if (np == `SFID_P_DUMMY)
              nbyte_next = {{(LEN_W-3){1'b0}}, dummy_reg};
            else
              nbyte_next = cnt_reg;
          end
        end
      end
      `SFID_S_WAITW:  need_wr = 1'b1;
      `SFID_S_HOLD:
      begin
        wait_next = wait_reg - 8'h01;
        if (wait_reg == 8'h00)
        begin
          cs_n_next  = 1'b1;                       // Rising chip select ends reads and repeats.
          wait_next  = GAP_CYC;
          state_next = `SFID_S_GAP;
        end
      end
      `SFID_S_GAP:
      begin
        wait_next = wait_reg - 8'h01;
        if (wait_reg == 8'h00)
          state_next = `SFID_S_IDLE;
      end
      default:        state_next = `SFID_S_IDLE;
    endcase
    // A missing write byte parks the link with sck low until the source catches up.
    if (need_wr)
    begin
      if (wr_valid)
      begin
        tx_next     = {wr_data, 24'h000000};
        wr_ack_next = 1'b1;
        state_next  = `SFID_S_RUN;
      end
      else
        state_next  = `SFID_S_WAITW;
    end
    active = (state_next == `SFID_S_SETUP) || (state_next == `SFID_S_RUN) || (state_next == `SFID_S_WAITW);
  end

  // ****************************************************************
  // Registers and pin drivers.
  // ****************************************************************
  // Lane values come from the next shift word so they settle a half period before the rise.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg     <= `SFID_S_IDLE;
      phase_reg     <= `SFID_P_OPC;
      tx_reg        <= 32'h00000000;
      dual_reg      <= 1'b0;
      bcnt_reg      <= 4'h0;
      nbyte_reg     <= {LEN_W{1'b0}};
      wait_reg      <= 8'h00;
      rx_reg        <= 8'h00;
      addr_reg      <= 32'h00000000;
      has_addr_reg  <= 1'b0;
      addr_dual_reg <= 1'b0;
      dummy_reg     <= 3'h0;
      dir_wr_reg    <= 1'b0;
      dir_rd_reg    <= 1'b0;
      rd_dual_reg   <= 1'b0;
      cnt_reg       <= {LEN_W{1'b0}};
      cmd_ready     <= 1'b0;
      wr_ack        <= 1'b0;
      rd_valid      <= 1'b0;
      rd_data       <= 8'h00;
      busy          <= 1'b0;
      flash_cs_n    <= 1'b1;
      lane0_out     <= 1'b0;
      lane0_oe      <= 1'b0;
      lane1_out     <= 1'b0;
      lane1_oe      <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      phase_reg     <= phase_next;
      tx_reg        <= tx_next;
      dual_reg      <= dual_next;
      bcnt_reg      <= bcnt_next;
      nbyte_reg     <= nbyte_next;
      wait_reg      <= wait_next;
      rx_reg        <= rx_next;
      addr_reg      <= addr_next;
      has_addr_reg  <= has_addr_next;
      addr_dual_reg <= addr_dual_next;
      dummy_reg     <= dummy_next;
      dir_wr_reg    <= dir_wr_next;
      dir_rd_reg    <= dir_rd_next;
      rd_dual_reg   <= rd_dual_next;
      cnt_reg       <= cnt_next;
      cmd_ready     <= cmd_ready_next;
      wr_ack        <= wr_ack_next;
      rd_valid      <= rd_valid_next;
      rd_data       <= rd_data_next;
      busy          <= (state_next != `SFID_S_IDLE);
      flash_cs_n    <= cs_n_next;
      // Dual words put the higher bit of each pair on the odd lane.
      lane1_out     <= dual_next && tx_next[31];
      lane0_out     <= dual_next ? tx_next[30] : tx_next[31];
      lane0_oe      <= active && !((phase_next == `SFID_P_RDATA) && dual_next);
      lane1_oe      <= active && (phase_next == `SFID_P_ADDR) && dual_next;
    end
  end
endmodule

// ===== tb/sfid_chk.sv
// Port checker for the serial flash host controller.
`timescale 1ns/100ps
`include "sfid_regs.vh"
module sfid_chk (
  input wire       clk,        // Clock.
  input wire       sys_rst,    // Reset.
  input wire       cmd_valid,  // Request.
  input wire       cmd_ready,  // Idle.
  input wire [7:0] cmd_opcode, // Opcode.
  input wire       busy,       // Busy.
  input wire       flash_sck,  // Link clock.
  input wire       flash_cs_n, // Select.
  input wire       lane0_out,  // Lane 0 value.
  input wire       lane0_oe,   // Lane 0 drive.
  input wire       lane1_oe,   // Lane 1 drive.
  input wire       rd_valid,   // Byte read.
  input wire       wr_ack      // Byte taken.
);
  // ****
  // Frame tracking
  // ****
  reg  [7:0]  op_q;  // Opcode in flight.
  reg  [11:0] n_q;   // Link clock rises in frame.
  reg         sck_q; // Link clock delayed.
  wire        rise   = flash_sck && !sck_q;
  wire        two_in = (op_q == `SFID_OP_FAST_DIO) || (op_q == `SFID_OP_MAKER_DIO);
  wire        two    = two_in || (op_q == `SFID_OP_FAST_DO);
  wire        lone   = (op_q == `SFID_OP_WREN) || (op_q == `SFID_OP_WRDI) || (op_q == `SFID_OP_WREN_VOL)
                    || (op_q == `SFID_OP_CHIP_A) || (op_q == `SFID_OP_CHIP_B) || (op_q == `SFID_OP_PWR_DOWN);
  // The count clears while deselected, so every frame starts from zero.
  always @(posedge clk)
  begin
    sck_q <= flash_sck;
    n_q   <= (sys_rst || flash_cs_n) ? 12'h000 : n_q + {11'h000, rise};
    if (cmd_valid && cmd_ready)
      op_q <= cmd_opcode;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_open;
    !flash_cs_n && busy && !cmd_ready;
  endsequence
  property p_take;
    s_take |=> s_open;
  endproperty
  a_take: assert property (p_take) else $error("No frame after take.");
  property p_first;
    $fell(flash_cs_n) |-> lane0_oe && (lane0_out == op_q[7]);
  endproperty
  a_first: assert property (p_first) else $error("First bit wrong.");
  property p_opc;
    rise && !flash_cs_n && (n_q < 12'h008) |-> lane0_oe && (lane0_out == op_q[3'h7 - n_q[2:0]]);
  endproperty
  a_opc: assert property (p_opc) else $error("Opcode bit wrong.");
  property p_idle;
    flash_cs_n |-> !flash_sck;
  endproperty
  a_idle: assert property (p_idle) else $error("Clock runs unselected.");
  property p_lane1;
    !flash_cs_n && !two_in |-> !lane1_oe;
  endproperty
  a_lane1: assert property (p_lane1) else $error("Lane 1 driven.");
  property p_edge;
    $rose(flash_cs_n) |-> (two ? n_q[1:0] == 2'h0 : n_q[2:0] == 3'h0);
  endproperty
  a_edge: assert property (p_edge) else $error("Frame ends mid byte.");
  property p_lone;
    $rose(flash_cs_n) && lone |-> n_q == 12'h008;
  endproperty
  a_lone: assert property (p_lone) else $error("Lone opcode length.");
  property p_rd;
    rd_valid |-> busy ##1 !rd_valid;
  endproperty
  a_rd: assert property (p_rd) else $error("Read pulse wrong.");
  property p_wr;
    wr_ack |-> (op_q == `SFID_OP_PROG || op_q == `SFID_OP_WR_STAT) ##1 !wr_ack;
  endproperty
  a_wr: assert property (p_wr) else $error("Write ack wrong.");
endmodule
bind sfid_host sfid_chk sfid_chk_i (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_opcode(cmd_opcode), .busy(busy), .flash_sck(flash_sck), .flash_cs_n(flash_cs_n), .lane0_out(lane0_out),
  .lane0_oe(lane0_oe), .lane1_oe(lane1_oe), .rd_valid(rd_valid), .wr_ack(wr_ack));

// ===== tb/sfid_flash_mdl.sv
// Behavioural serial flash device model.
`timescale 1ns/100ps
module sfid_flash_mdl #(
  parameter [7:0]  MAKER = 8'h5A,     // Arbitrary maker code.
  parameter [7:0]  DEVID = 8'h3C,     // Arbitrary device code.
  parameter [15:0] JTYPE = 16'h2114,  // Arbitrary type and size.
  parameter [63:0] UID   = 64'h0     // Arbitrary serial number.
) (
  input  wire  sck,    // Link clock.
  input  wire  cs_n,   // Select.
  input  wire  d0_in,  // Lane 0 level.
  input  wire  d1_in,  // Lane 1 level.
  output logic d0_out, // Lane 0 value.
  output logic d0_oe,  // Lane 0 drive.
  output logic d1_out, // Lane 1 value.
  output logic d1_oe   // Lane 1 drive.
);
  logic [7:0]  op, sh, b, stat, lop, wbuf [0:7];
  logic [23:0] addr, laddr;
  int          n, st, j, lbits;
  // Returned byte k of the current instruction.
  function automatic logic [7:0] ob(input int k);
    logic [23:0] x;
    x = addr + k;
    case (op)
      8'h05: ob = stat;
      8'h9F: ob = {MAKER, JTYPE} >> (16 - 8 * k);
      8'hAB: ob = DEVID;
      8'h90, 8'h92: ob = k[0] ? DEVID : MAKER;
      8'h4B: ob = UID >> (56 - 8 * (k % 8));
      default: ob = x[7:0] ^ x[23:16];
    endcase
  endfunction
  initial {d0_out, d0_oe, d1_out, d1_oe, stat} = '0;
  // A falling select opens a frame.
  always @(negedge cs_n)
    n = 0;
  // Rises take the opcode, the address, then written bytes.
  always @(posedge sck)
  begin
    n = n + 1;
    sh = {sh[6:0], d0_in};
    if (n == 8)
      op = sh;
    if ((op == 8'hBB || op == 8'h92) && n > 8 && n <= 20)
      addr = {addr[21:0], d1_in, d0_in};
    else if (op != 8'hBB && op != 8'h92 && n > 8 && n <= 32)
      addr = {addr[22:0], d0_in};
    if (op == 8'h02 && n > 32 && n % 8 == 0 && n <= 2080)
      wbuf[(n / 8 - 5) % 8] = sh;
  end
  // Falls launch returned bits; unknown opcodes never start output.
  always @(negedge sck)
  begin
    st = (op == 8'h03 || op == 8'hAB || op == 8'h90) ? 32 : (op == 8'h0B || op == 8'h3B || op == 8'h4B) ? 40
       : (op == 8'hBB || op == 8'h92) ? 24 : (op == 8'h05 || op == 8'h9F) ? 8 : 99999;
    j = n - st;
    if (!cs_n && j >= 0 && (op == 8'h3B || op == 8'hBB || op == 8'h92))
    begin
      b = ob(j / 4) >> (6 - 2 * (j % 4));
      {d1_out, d0_out} <= b[1:0];
      {d1_oe, d0_oe}   <= 2'b11;
    end
    else if (!cs_n && j >= 0)
    begin
      b = ob(j / 8);
      d1_out <= b[7 - j % 8];
      d1_oe  <= 1'b1;
    end
  end
  // A rising select ends the frame; a status write needs exactly one byte.
  always @(posedge cs_n)
  begin
    {d1_oe, d0_oe} <= 2'b00;
    lop   = op;
    laddr = addr;
    lbits = n;
    if (op == 8'h01 && n == 16)
      stat = sh;
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the flash host against the device model.
`timescale 1ns/100ps
`include "sfid_regs.vh"
module testbench;
  localparam [7:0]  MAKER = 8'hA6;                // Arbitrary maker code.
  localparam [7:0]  DEVID = 8'h4D;                // Arbitrary device code.
  localparam [15:0] JTYPE = 16'h5E21;             // Arbitrary type and size.
  localparam [63:0] UID   = 64'hC3A51E2D77889B4F; // Arbitrary serial number.
  logic        clk = 0, sys_rst = 1, cmd_valid = 0, wr_valid = 0, l0 = 0, l1 = 0;
  logic [7:0]  cmd_opcode = 0, cmd_mode = 0, stat_exp = 0, wdat [0:7], exp_q [$];
  logic [23:0] cmd_addr = 0;
  logic [15:0] cmd_count = 0;
  wire         cmd_ready, wr_ack, rd_valid, busy, sck, cs_n, h0, h0_oe, h1, h1_oe, d0, d0_oe, d1, d1_oe;
  wire  [7:0]  rd_data;
  int          error_cnt = 0, tests_run = 0, wi = 0, cyc = 0;
  logic [7:0]  nd [10] = '{8'h06, 8'h04, 8'h50, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'hB9, 8'hFF};
  logic [7:0]  ro [10] = '{8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h05, 8'h9F, 8'hAB, 8'h90, 8'h92, 8'h4B};
  int          rc [10] = '{3, 2, 3, 2, 2, 3, 2, 2, 2, 8};
  sfid_host #(.SCK_HALF(5)) sfid_host_i (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_mode(cmd_mode), .cmd_count(cmd_count), .wr_data(wdat[wi[2:0]]),
    .wr_valid(wr_valid), .wr_ack(wr_ack), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .flash_sck(sck),
    .flash_cs_n(cs_n), .lane0_out(h0), .lane0_oe(h0_oe), .lane0_in(l0), .lane1_out(h1), .lane1_oe(h1_oe), .lane1_in(l1));
  sfid_flash_mdl #(.MAKER(MAKER), .DEVID(DEVID), .JTYPE(JTYPE), .UID(UID)) sfid_flash_mdl_i (.sck(sck), .cs_n(cs_n),
    .d0_in(l0), .d1_in(l1), .d0_out(d0), .d0_oe(d0_oe), .d1_out(d1), .d1_oe(d1_oe));
  initial forever #2 clk = ~clk;
  // Pin levels; an undriven lane toggles so a stale value never reads as data.
  always @(posedge clk)
  begin
    l0 <= h0_oe ? h0 : d0_oe ? d0 : ~l0;
    l1 <= h1_oe ? h1 : d1_oe ? d1 : ~l1;
  end
  // Next write byte after each acknowledge.
  always @(negedge clk)
    if (wr_ack === 1'b1)
      wi <= wi + 1;
  function automatic logic [7:0] expb(input logic [7:0] op, input logic [23:0] a, input int k);
    logic [23:0] x;
    x = a + k;
    case (op)
      `SFID_OP_RD_STAT:                      expb = stat_exp;
      `SFID_OP_JEDEC_ID:                     expb = (k == 0) ? MAKER : (k == 1) ? JTYPE[15:8] : JTYPE[7:0];
      `SFID_OP_REL_PD:                       expb = DEVID;
      `SFID_OP_MAKER_ID, `SFID_OP_MAKER_DIO: expb = k[0] ? DEVID : MAKER;
      `SFID_OP_UNIQUE_ID:                    expb = UID[63 - 8 * k -: 8];
      default:                               expb = x[7:0] ^ x[23:16];
    endcase
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One instruction, entered at a falling edge; expected read bytes are queued.
  task automatic do_cmd(input logic [7:0] op, input int cnt, input bit rd);
    int t;
    cmd_opcode = op;
    cmd_addr   = $urandom;
    cmd_mode   = $urandom;
    cmd_count  = cnt[15:0];
    wi         = 0;
    wr_valid   = !rd && cnt > 0;
    for (int k = 0; k < cnt && rd; k++)
      exp_q.push_back(expb(op, cmd_addr, k));
    cmd_valid = 1'b1;
    t = 0;
    do @(posedge clk); while (cmd_ready !== 1'b1 && t++ < 9000);
    @(negedge clk);
    cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1 && t++ < 9000)
      @(negedge clk);
    if (t > 8999)
      error_cnt++;
    wr_valid = 1'b0;
  endtask
  // Every returned byte is matched against the oldest note.
  always @(posedge clk)
    if (rd_valid === 1'b1)
    begin
      chk("rd_data", exp_q.size() > 0 ? exp_q[0] : 64'h100, rd_data);
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
  // Hang guard, well above the roughly eight thousand cycles the run needs.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      give_verdict;
    end
  end
  // Main sequence: status write, page program, lone and erase opcodes, then every read form.
  initial
  begin
    void'($urandom(16));
    for (int k = 0; k < 8; k++)
      wdat[k] = $urandom;
    repeat (8) @(negedge clk);
    sys_rst  = 1'b0;
    stat_exp = wdat[0];
    repeat (2) @(negedge clk);
    do_cmd(`SFID_OP_WR_STAT, 1, 0);
    chk("stat", stat_exp, sfid_flash_mdl_i.stat);
    do_cmd(`SFID_OP_PROG, 3, 0);
    chk("paddr", cmd_addr, sfid_flash_mdl_i.laddr);
    chk("pbits", 56, sfid_flash_mdl_i.lbits);
    for (int k = 0; k < 3; k++)
      chk("pdata", wdat[k], sfid_flash_mdl_i.wbuf[k]);
    for (int i = 0; i < 10; i++)
    begin
      do_cmd(nd[i], 0, 0);
      chk("op", nd[i], sfid_flash_mdl_i.lop);
      chk("bits", (i >= 3 && i <= 5) ? 32 : 8, sfid_flash_mdl_i.lbits);
      if (i >= 3 && i <= 5)
        chk("eaddr", cmd_addr, sfid_flash_mdl_i.laddr);
    end
    for (int i = 0; i < 10; i++)
      do_cmd(ro[i], rc[i], 1);
    chk("left", 0, exp_q.size());
    give_verdict;
  end
endmodule
